/* verif/cbx_checker.sv */
// Assertions on the branch executor ports.
`timescale 1ns/1ps
module cbx_checker #(parameter int PC_W = 21) (
  input wire logic mclk, rst, instr_valid, flag_ovf, flag_zero, flag_neg, pc_load, flush,
  input wire logic branch_taken, branch_done, flags_we,
  input wire logic [1:0] qphase,
  input wire logic [15:0] instr,
  input wire logic [PC_W-1:0] pc_inc, pc_target);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_br(h, f);
    qphase == 2'h3 && instr_valid && !$past(flush) && instr[15:8] == h && f;
  endsequence
  sequence s_fl;
    flush[*3] ##1 branch_done;
  endsequence
  chk_ovf_take: assert property (s_br(8'he5, !flag_ovf) |=> pc_load) else $error("ovf");
  chk_zero_take: assert property (s_br(8'he1, !flag_zero) |=> pc_load) else $error("zero");
  chk_neg_take: assert property (s_br(8'he7, !flag_neg) |=> branch_taken) else $error("neg");
  chk_set_skip: assert property (s_br(8'he5, flag_ovf) |=> !pc_load) else $error("skip");
  chk_target_sum: assert property (pc_load |-> pc_target ==
    PC_W'($past(pc_inc) + (PC_W'($signed($past(instr[7:0]))) << 1))) else $error("target");
  chk_flush_seq: assert property (pc_load |=> s_fl) else $error("flush");
  chk_one_pulse: assert property (pc_load |=> !pc_load) else $error("pulse");
  chk_flags_hold: assert property (!flags_we) else $error("flags");
endmodule
bind cbx_exec cbx_checker #(.PC_W(PC_W)) chk (.*);

/* verif/cbx_fetch.sv */
// Fetch-side model: quarter phase counter and incremented program counter.
`timescale 1ns/1ps
module cbx_fetch (
  input wire logic mclk, rst, pc_load,
  input wire logic [20:0] pc_target,
  output logic [1:0] qphase,
  output logic [20:0] pc_inc);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      qphase <= 2'h0;
      pc_inc <= 21'h00_0002;
    end else begin
      qphase <= qphase + 2'h1;
      if (pc_load) pc_inc <= pc_target;
      else if (qphase == 2'h3) pc_inc <= pc_inc + 21'h00_0002;
    end
  end
endmodule

/* verif/tb_conditional_branch_exec.sv */
// Self-checking bench for the branch executor.
`timescale 1ns/1ps
module tb_conditional_branch_exec;
  logic mclk = 0, rst = 1, instr_valid = 0, flag_ovf = 0, flag_zero = 0, flag_neg = 0;
  logic pc_load, flush, branch_taken, branch_done, flags_we;
  logic [15:0] instr = 16'h0000;
  logic [1:0] qphase;
  logic [20:0] pc_inc, pc_target;
  logic [7:0] ops [4] = '{8'he5, 8'he1, 8'he7, 8'h0f};
  int error_cnt = 0, comparisons = 0;
  always #5 mclk = ~mclk;
  cbx_exec dut (.*);
  cbx_fetch fetch (.*);
  task automatic check(string n, logic [20:0] s, e);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic results;
    if (error_cnt == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    int pc, tk;
    logic [7:0] hi;
    void'($urandom(32'had23_fa51));
    repeat (20) @(posedge mclk);
    #1 rst = 0;
    for (int i = 0; i < 80; i++) begin
      while (qphase !== 2'h0) begin
        @(posedge mclk);
        #1;
      end
      hi = ops[i % 4];
      {flag_ovf, flag_zero, flag_neg} = 3'($urandom);
      instr_valid = 3'($urandom) != 0;
      instr = {hi, 8'($urandom)};
      pc = pc_inc;
      tk = instr_valid && (hi == 8'he5 && !flag_ovf || hi == 8'he1 && !flag_zero ||
        hi == 8'he7 && !flag_neg);
      repeat (4) @(posedge mclk);
      #1 check("load_done", {pc_load, branch_done}, {tk, !tk && instr_valid && hi != 8'h0f});
      check("taken", branch_taken, tk);
      check("flags_we", flags_we, 1'b0);
      if (tk) begin
        check("target", pc_target, 21'(pc + 2 * $signed(instr[7:0])));
        // The taken branch stays on the bus through the flush cycle and must not fire again.
        @(posedge mclk);
        #1 check("flush", flush, 1'b1);
        repeat (3) @(posedge mclk);
        #1 check("flush_end", {pc_load, branch_done, flush}, 3'b010);
      end
    end
    results;
  end
  initial begin
    #20000;
    error_cnt++;
    results;
  end
endmodule

/* verilog/cbx_dec_if.sv */
// Interface carrying decode results from the decoder to the executor.
`timescale 1ns/1ps
interface cbx_dec_if;
  cbx_pkg::cbx_op_e op;
  logic cond_ok;
  logic signed [8:0] disp;
  modport dec (output op, output cond_ok, output disp);
  modport exe (input op, input cond_ok, input disp);
endinterface

/* verilog/cbx_decode.sv */
// Opcode decoder and flag test for the conditional branches.
`timescale 1ns/1ps
`include "cbx_params.svh"
module cbx_decode (
  // Instruction and flags
  input wire logic [15:0] instr,
  input wire logic flag_ovf,
  input wire logic flag_zero,
  input wire logic flag_neg,
  // Decode result
  cbx_dec_if.dec dec
);
  always_comb begin
    dec.op = cbx_pkg::CBX_OP_NONE;
    dec.cond_ok = 1'b0;
    unique case (instr[15:8])
      `CBX_OP_NO_OVF_HI: begin
        dec.op = cbx_pkg::CBX_OP_OVF;
        dec.cond_ok = ~flag_ovf;
      end
      `CBX_OP_NONZERO_HI: begin
        dec.op = cbx_pkg::CBX_OP_ZERO;
        dec.cond_ok = ~flag_zero;
      end
      `CBX_OP_NOT_NEG_HI: begin
        dec.op = cbx_pkg::CBX_OP_NEG;
        dec.cond_ok = ~flag_neg;
      end
      default: begin
        dec.op = cbx_pkg::CBX_OP_NONE;
        dec.cond_ok = 1'b0;
      end
    endcase
  end
  // Signed offset doubled so the target lands on a word boundary.
  assign dec.disp = {instr[7:0], 1'b0};
endmodule

/* verilog/cbx_exec.sv */
// Execution of the conditional relative branches on no overflow, nonzero and not negative.
`timescale 1ns/1ps
`include "cbx_params.svh"
module cbx_exec #(
  parameter int PC_W = `CBX_PC_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Instruction phase and fetched word
  input wire logic [1:0] qphase,
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  input wire logic [PC_W-1:0] pc_inc,
  // Status flags, read only
  input wire logic flag_ovf,
  input wire logic flag_zero,
  input wire logic flag_neg,
  // Program counter load and pipeline control
  output logic pc_load,
  output logic [PC_W-1:0] pc_target,
  output logic flush,
  output logic branch_taken,
  output logic branch_done,
  output logic flags_we
);
  cbx_dec_if dec_bus ();
  cbx_pkg::cbx_state_e state_q;
  logic is_branch;
  logic take;
  logic last_phase;

  cbx_decode u_dec (
    .instr(instr),
    .flag_ovf(flag_ovf),
    .flag_zero(flag_zero),
    .flag_neg(flag_neg),
    .dec(dec_bus.dec)
  );

  function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] base,
                                                 input logic signed [8:0] disp);
    logic signed [PC_W:0] sum;
    sum = $signed({1'b0, base}) + (PC_W+1)'(disp);
    rel_target = sum[PC_W-1:0];
  endfunction

  assign last_phase = (qphase == `CBX_Q_LAST);
  assign is_branch = instr_valid && (dec_bus.op != cbx_pkg::CBX_OP_NONE);
  assign take = is_branch && dec_bus.cond_ok && (state_q == cbx_pkg::CBX_ST_EXEC);

  // A taken branch spends its second cycle as a no-operation flush.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= cbx_pkg::CBX_ST_EXEC;
    end else if (last_phase) begin
      unique case (state_q)
        cbx_pkg::CBX_ST_EXEC: begin
          if (take) begin
            state_q <= cbx_pkg::CBX_ST_FLUSH;
          end
        end
        cbx_pkg::CBX_ST_FLUSH: begin
          state_q <= cbx_pkg::CBX_ST_EXEC;
        end
        default: begin
          state_q <= cbx_pkg::CBX_ST_EXEC;
        end
      endcase
    end
  end

  // The program counter is written only in the last phase of a taken branch.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_load <= 1'b0;
      pc_target <= PC_W'(`CBX_PC_RESET);
    end else begin
      pc_load <= take && last_phase;
      if (take && last_phase) begin
        // pc_inc already equals branch address plus one word step.
        pc_target <= rel_target(pc_inc, dec_bus.disp);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flush <= 1'b0;
      branch_taken <= 1'b0;
      branch_done <= 1'b0;
    end else begin
      flush <= (state_q == cbx_pkg::CBX_ST_FLUSH) && !(last_phase);
      branch_taken <= take && last_phase;
      branch_done <= last_phase && ((is_branch && !take && state_q == cbx_pkg::CBX_ST_EXEC)
                     || state_q == cbx_pkg::CBX_ST_FLUSH);
    end
  end

  // These branches never write status, taken or not.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_we <= 1'b0;
    end else begin
      flags_we <= 1'b0;
    end
  end
endmodule

/* verilog/cbx_params.svh */
// Constants for the conditional branch execution block.
`ifndef CBX_PARAMS_SVH
`define CBX_PARAMS_SVH
`define CBX_OP_NO_OVF_HI 8'hE5
`define CBX_OP_NONZERO_HI 8'hE1
`define CBX_OP_NOT_NEG_HI 8'hE7
`define CBX_PC_W 21
`define CBX_WORD_STEP 2
`define CBX_PC_RESET 21'h00_0000
`define CBX_Q_LAST 2'h3
`endif

/* verilog/cbx_pkg.sv */
// Types for the conditional branch execution block.
package cbx_pkg;
  typedef enum logic [1:0] {
    CBX_OP_NONE = 2'b00,
    CBX_OP_OVF = 2'b01,
    CBX_OP_ZERO = 2'b10,
    CBX_OP_NEG = 2'b11
  } cbx_op_e;
  typedef enum logic [1:0] {
    CBX_ST_EXEC = 2'b00,
    CBX_ST_FLUSH = 2'b01
  } cbx_state_e;
endpackage
